// File: inc/nvds_pkg.sv
/*
 Constants for the nonvolatile default store and lock block: register offset,
 field positions, reset values and copy timing.
 Assumes a register port decoded by the serial configuration bus front end.
*/
// How it works
// (R1) Writing one to the copy-trigger bit copies selected bits into the store; zero does nothing.
// (R2) The device clears the copy-trigger bit itself once every bit is written.
// (R3) With lock-request set, the store locks after the next copy completes.
// (R4) A locked store is unlocked only by reset, when its request was written on the last cell's edge; later copies leave contents unchanged.
// (R5) A read-only status bit shows one when locked, zero while updatable.
// (R6) Reserved low field ignores writes and always reads zero.
// (R7) Lock-request is stored and restored at power-up; trigger and status follow live state.
package nvds_pkg;
   localparam logic [7:0] NVDS_CTRL_ADDR = 8'h_ff;
   localparam logic [7:0] NVDS_CTRL_RESET = 8'h_ff;
   localparam int NVDS_TRIG_BIT = 7;
   localparam int NVDS_LOCKREQ_BIT = 6;
   localparam int NVDS_LOCKED_BIT = 5;
   localparam int NVDS_DATA_W = 16;
   localparam int NVDS_WRITE_NS = 400;
   localparam int NVDS_CLK_NS = 40;
   localparam int NVDS_BIT_CYCLES = (NVDS_WRITE_NS + NVDS_CLK_NS - 1) / NVDS_CLK_NS;
   typedef enum logic [2:0] {
      NVDS_IDLE = 3'b001,
      NVDS_COPY = 3'b010,
      NVDS_DONE = 3'b100
   } nvds_state_t;
endpackage : nvds_pkg

// File: verilog/nvds_cell.sv
/*
 One nonvolatile storage bit with write gate.
 Assumes the controller raises write only when the store is unlocked.
*/
`timescale 1ns/1ps
module nvds_cell (
   input wire logic clock_in,
   input wire logic write_in,
   input wire logic data_in,
   output logic bit_out
);
   // Cells keep state over power loss and reset; a fresh store starts erased to zero.
   logic level = 1'b0;

   always_ff @(posedge clock_in) begin
      if (write_in) begin
         level <= data_in;
      end
   end

   assign bit_out = level;
endmodule : nvds_cell

// File: verilog/nvds_store.sv
/*
 Control register and copy sequencer for the nonvolatile default store.
 Assumes the bus front end delivers one-cycle write strobes with an address and
 reads by address alone; shadow configuration bits come from the other registers.
*/
`timescale 1ns/1ps
module nvds_store import nvds_pkg::*; #(
   parameter int DATA_W = NVDS_DATA_W
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [7:0] addr_in,
   input wire logic wr_en_in,
   input wire logic [7:0] wr_data_in,
   input wire logic [DATA_W-1:0] config_bits_in,
   output logic [7:0] rd_data_out,
   output logic [DATA_W-1:0] stored_bits_out,
   output logic nvm_locked_flag_out,
   output logic busy_out
);
   localparam int CNT_W = $clog2(NVDS_BIT_CYCLES + 1);
   localparam int IDX_W = $clog2(DATA_W + 2);
   localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(NVDS_BIT_CYCLES - 1);
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DATA_W);

   nvds_state_t state;
   logic trig;
   logic lockreq;
   logic locked;
   logic [CNT_W-1:0] cnt;
   logic [IDX_W-1:0] idx;
   logic [DATA_W:0] cell_q;
   logic [DATA_W:0] cell_d;
   logic [DATA_W:0] cell_we;
   logic ctrl_wr;
   logic bit_done;
   logic power_up;

   assign ctrl_wr = wr_en_in && (addr_in == NVDS_CTRL_ADDR);
   assign bit_done = (state == NVDS_COPY) && (cnt == BIT_LAST);
   // Index DATA_W is the stored copy of the lock-request bit.
   assign cell_d = {lockreq, config_bits_in};

   genvar gi;
   generate
      for (gi = 0; gi <= DATA_W; gi++) begin : g_cell
         // A cell is written only by the unlocked sequencer.
         assign cell_we[gi] = bit_done && !locked && (idx == IDX_W'(gi)); // R4
         nvds_cell u_cell (
            .clock_in(clock_in),
            .write_in(cell_we[gi]),
            .data_in(cell_d[gi]),
            .bit_out(cell_q[gi])
         );
      end
   endgenerate

   // One cycle after reset release the stored lock request is recalled.
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         power_up <= 1'b1;
      end else begin
         power_up <= 1'b0;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state <= NVDS_IDLE;
         cnt <= '0;
         idx <= '0;
      end else begin
         case (state)
            NVDS_IDLE: begin
               if (trig) begin // R1
                  state <= NVDS_COPY;
                  cnt <= '0;
                  idx <= '0;
               end
            end
            NVDS_COPY: begin
               if (bit_done) begin
                  cnt <= '0;
                  if (idx == IDX_LAST) begin
                     state <= NVDS_DONE;
                  end else begin
                     idx <= idx + IDX_W'(1);
                  end
               end else begin
                  cnt <= cnt + CNT_W'(1);
               end
            end
            NVDS_DONE: state <= NVDS_IDLE;
            default: state <= NVDS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         trig <= 1'b0;
      end else if (state == NVDS_DONE) begin
         trig <= 1'b0; // R2
      end else if (ctrl_wr && wr_data_in[NVDS_TRIG_BIT]) begin
         trig <= 1'b1; // R1
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         lockreq <= 1'b0;
      end else if (power_up) begin
         lockreq <= cell_q[DATA_W]; // R7
      end else if (ctrl_wr) begin
         lockreq <= wr_data_in[NVDS_LOCKREQ_BIT];
      end
   end

   // The lock state is recalled with the store, so a locked part stays locked unless its request was written on the last cell's edge.
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         locked <= 1'b0;
      end else if (power_up) begin
         locked <= cell_q[DATA_W]; // R4
      end else if (state == NVDS_DONE && (lockreq || cell_q[DATA_W])) begin
         // A stored request also locks, so a request cleared as the copy ends cannot leak.
         locked <= 1'b1; // R3
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         rd_data_out <= 8'h_00;
      end else begin
         rd_data_out <= 8'h_00; // R6
         if (addr_in == NVDS_CTRL_ADDR) begin
            rd_data_out[NVDS_TRIG_BIT] <= trig;
            rd_data_out[NVDS_LOCKREQ_BIT] <= lockreq;
            rd_data_out[NVDS_LOCKED_BIT] <= locked; // R5
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         stored_bits_out <= '0;
         nvm_locked_flag_out <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         stored_bits_out <= cell_q[DATA_W-1:0];
         nvm_locked_flag_out <= locked; // R5
         busy_out <= trig;
      end
   end

   // Mirrors and read-back trail the live state by one edge; the recall edge is skipped.
   trig_start_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
      (ctrl_wr && wr_data_in[NVDS_TRIG_BIT] && state == NVDS_IDLE) |=> trig)
      else $error("copy trigger not taken");
   zero_noop_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
      (!trig && state == NVDS_IDLE && !(ctrl_wr && wr_data_in[NVDS_TRIG_BIT])) |=> !trig)
      else $error("trigger set without write");
   copy_start_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
      (state == NVDS_IDLE && trig) |=> (state == NVDS_COPY))
      else $error("copy did not start");
   trig_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
      (state == NVDS_COPY) |-> trig)
      else $error("trigger lost during copy");
   busy_copy_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
      busy_out == $past(trig))
      else $error("busy does not follow trigger");
   read_trig_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
      (addr_in == NVDS_CTRL_ADDR) |=> (rd_data_out[NVDS_TRIG_BIT] == $past(trig)))
      else $error("trigger read-back wrong");
   stored_copy_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R1
      !power_up |-> (stored_bits_out == $past(cell_q[DATA_W-1:0])))
      else $error("stored bits not mirrored");
   self_clear_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R2
      (state == NVDS_DONE) |=> !trig)
      else $error("trigger not cleared after copy");
   done_once_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R2
      (state == NVDS_DONE) |=> (state == NVDS_IDLE))
      else $error("copy end state held");
   bit_count_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R2
      (state == NVDS_COPY) |-> (cnt <= BIT_LAST))
      else $error("bit timer out of range");
   idx_range_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R2
      (state == NVDS_COPY) |-> (idx <= IDX_LAST))
      else $error("cell index out of range");
   lock_after_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R3
      (state == NVDS_DONE && lockreq) |=> locked)
      else $error("lock not applied after copy");
   stored_lock_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R4
      (state == NVDS_DONE && cell_q[DATA_W]) |=> locked)
      else $error("stored lock not applied");
   lock_sticky_a: assert property (@(posedge clock_in) disable iff (!rst_n_in || power_up) // R4
      locked |=> locked)
      else $error("store unlocked");
   no_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R4
      locked |-> (cell_we == '0))
      else $error("locked store written");
   contents_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R4
      locked |=> $stable(cell_q))
      else $error("locked store contents changed");
   status_bit_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R5
      (addr_in == NVDS_CTRL_ADDR) |=> rd_data_out[NVDS_LOCKED_BIT] == $past(locked))
      else $error("lock status wrong");
   flag_copy_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R5
      nvm_locked_flag_out == $past(locked))
      else $error("lock flag does not follow lock");
   reserved_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R6
      rd_data_out[4:0] == 5'h_00)
      else $error("reserved field nonzero");
   other_addr_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R6
      (addr_in != NVDS_CTRL_ADDR) |=> (rd_data_out == 8'h_00))
      else $error("other address reads nonzero");
   recall_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
      power_up |=> lockreq == $past(cell_q[DATA_W]))
      else $error("lock request not recalled");
   read_lockreq_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R7
      (addr_in == NVDS_CTRL_ADDR) |=> (rd_data_out[NVDS_LOCKREQ_BIT] == $past(lockreq)))
      else $error("lock request read-back wrong");
endmodule : nvds_store

// File: sim/nvds_host_model.sv
/* Host side model: drives the store's register port like the bus front end.
 Assumes one clock; the store samples its inputs on the rising edge. */
`timescale 1ns/1ps
module nvds_host_model (
   input wire logic clock_in,
   input wire logic [7:0] rd_data_in,
   output logic [7:0] addr_out,
   output logic wr_en_out,
   output logic [7:0] wr_data_out
);
   initial begin
      addr_out = 8'h_ff;
      wr_en_out = 1'b0;
      wr_data_out = 8'h_00;
   end
   // Data is inverted after the strobe so a stale value never looks valid.
   task automatic wr(input logic [7:0] d);
      @(negedge clock_in);
      addr_out = 8'h_ff;
      wr_data_out = d;
      wr_en_out = 1'b1;
      @(negedge clock_in);
      wr_en_out = 1'b0;
      wr_data_out = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock_in);
      addr_out = a;
      @(negedge clock_in);
      d = rd_data_in;
   endtask : rd
endmodule : nvds_host_model

// File: sim/test_nvds_store.sv
/* Self-checking bench for the store: copy, reserved bits, lock, relock, reset.
 Assumes the host model for register access and a 25 MHz clock. */
`timescale 1ns/1ps
module test_nvds_store import nvds_pkg::*;;
   logic clock_in, rst_n_in, wr_en, locked, busy;
   logic [7:0] addr, wr_data, rd_data, d;
   logic [15:0] cfg, stored;
   int miscompares = 0;
   int cmp_count = 0;
   nvds_store uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr),
      .wr_en_in(wr_en), .wr_data_in(wr_data), .config_bits_in(cfg),
      .rd_data_out(rd_data), .stored_bits_out(stored),
      .nvm_locked_flag_out(locked), .busy_out(busy));
   nvds_host_model host (.clock_in(clock_in), .rd_data_in(rd_data),
      .addr_out(addr), .wr_en_out(wr_en), .wr_data_out(wr_data));
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("compares %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up
   // Busy must rise within a few cycles when a copy starts, then fall in bounds.
   task automatic copy(input logic [7:0] w, input logic [15:0] c, input logic go);
      int n;
      @(negedge clock_in);
      cfg = c;
      host.wr(w);
      n = 0;
      while (busy !== 1'b1 && n < 8) begin
         @(negedge clock_in);
         n++;
      end
      chk(busy, go);
      host.rd(8'h_ff, d);
      chk(d[NVDS_TRIG_BIT], go);
      n = 0;
      while (busy === 1'b1 && n < 400) begin
         @(negedge clock_in);
         n++;
      end
      chk(busy, 1'b0);
   endtask : copy
   task automatic s_plain;
      copy(8'h_80, 16'h_a5c3, 1'b1);
      chk(stored, 16'h_a5c3);
      chk(locked, 1'b0);
      host.rd(8'h_ff, d);
      chk(d, 8'h_00);
   endtask : s_plain
   task automatic s_zero;
      copy(8'h_3f, 16'h_ffff, 1'b0);
      chk(stored, 16'h_a5c3);
      chk(locked, 1'b0);
      host.rd(8'h_ff, d);
      chk(d, 8'h_00);
   endtask : s_zero
   task automatic s_lock;
      copy(8'h_c0, 16'h_5a3c, 1'b1);
      chk(stored, 16'h_5a3c);
      chk(locked, 1'b1);
      host.rd(8'h_ff, d);
      chk(d, 8'h_60);
   endtask : s_lock
   task automatic s_relock;
      copy(8'h_9f, 16'h_0ff0, 1'b1);
      chk(stored, 16'h_5a3c);
      chk(locked, 1'b1);
   endtask : s_relock
   task automatic s_reset;
      @(negedge clock_in);
      rst_n_in = 1'b0;
      repeat (2) @(negedge clock_in);
      rst_n_in = 1'b1;
      repeat (2) @(negedge clock_in);
      chk(locked, 1'b1);
      host.rd(8'h_ff, d);
      chk(d, 8'h_60);
      host.rd(8'h_10, d);
      chk(d, 8'h_00);
   endtask : s_reset
   initial begin
      rst_n_in = 1'b0;
      cfg = 16'h_0000;
      repeat (10) @(negedge clock_in);
      rst_n_in = 1'b1;
      repeat (2) @(negedge clock_in);
      s_plain();
      s_zero();
      s_lock();
      s_relock();
      s_reset();
      wrap_up();
   end
   initial begin
      repeat (8 * (NVDS_DATA_W + 1) * NVDS_BIT_CYCLES + 1000) @(posedge clock_in);
      miscompares++;
      wrap_up();
   end
endmodule : test_nvds_store
